// [core/rtu_frame_handler.sv]
// slave side frame handler for an rtu serial link
// assumes a uart on the same clock delivers and takes bytes, and a
// parameter store answers access requests with a one-cycle acknowledge
// Summary of operation
// - station 1..247 own, 0 is broadcast
// - broadcast requests executed, never answered
// - idle over 3.5 characters ends frame
// - drive line only while replying
// - transmit only in answer to a request
// - own-address requests with a good crc get a reply while station_id is 1..247
// - 0x03 reads words, 0x06 writes one
// - only 16-bit word transfers
// - read count limited to twelve words
// - parameter address sent high byte first
// - read count field, high byte first
// - write carries no count, one word
// - data words high byte first
// - faults produce an error reply instead
// - causes 01 op, 02 addr, 03 data, 04 busy
// - crc16 from all ones, reflected polynomial
// - crc appended low byte then high
// - received crc checked, mismatch is error
`timescale 1ns/10ps
module rtu_frame_handler import rtu_pkg::*; #(
  parameter longint GAP_CYCLES = RTU_GAP_CYCLES_DEF,
  parameter int MAX_WORDS = RTU_MAX_WORDS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] station_id,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_busy,
  output logic tx_en,
  output logic par_req,
  output logic par_we,
  output logic [15:0] par_addr,
  output logic [15:0] par_wdata,
  input wire logic par_ack,
  input wire logic [15:0] par_rdata,
  input wire logic par_fail,
  input wire logic [7:0] par_fail_code,
  output logic crc_err,
  output logic frame_drop
);
  localparam int GW = $clog2(GAP_CYCLES + 1);
  localparam int IW = 5; // reply byte index, reaches 3 + 2 * 12

  rtu_strm_if #(.WIDTH(8)) push_s (); // handler to buffer
  rtu_strm_if #(.WIDTH(8)) pop_s (); // buffer to uart

  rtu_state_type state_q; // frame handler state
  logic [GW-1:0] gap_q; // idle cycles since last byte
  logic frame_end; // gap expired with bytes held
  logic [7:0] rx_mem_q [RTU_REQ_BYTES]; // request bytes
  logic [3:0] rx_cnt_q; // bytes in current frame
  logic rx_ovf_q; // frame longer than any request
  logic [15:0] crc_rx_q; // running crc of received bytes
  logic [15:0] crc_tx_q; // running crc of reply bytes
  logic [15:0] words_q [MAX_WORDS]; // words read for the reply
  logic [3:0] word_n_q; // words asked for
  logic [3:0] word_ix_q; // word being accessed
  logic bcast_q; // request was a broadcast
  logic rep_err_q; // reply is an error reply
  logic [7:0] err_code_q; // cause carried by the error reply
  logic [IW-1:0] tx_ix_q; // reply byte index
  logic [IW-1:0] rep_len; // reply length without crc
  logic [7:0] rep_byte; // reply byte at tx_ix_q
  logic pushed; // a reply byte entered the buffer
  logic buf_empty; // nothing left in the buffer
  logic [15:0] req_addr; // parameter address of the request
  logic [15:0] req_cnt; // count or write data field
  logic [7:0] req_func; // operation code
  logic [7:0] req_station; // destination station

  // request fields, two-byte fields high byte first
  assign req_station = rx_mem_q[RTU_IX_ADDR];
  assign req_func = rx_mem_q[RTU_IX_FUNC];
  assign req_addr = {rx_mem_q[RTU_IX_RA_HI], rx_mem_q[RTU_IX_RA_LO]};
  assign req_cnt = {rx_mem_q[RTU_IX_CN_HI], rx_mem_q[RTU_IX_CN_LO]};

  // gap timer; restarts on every byte, holds at the limit
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gap_q <= '0;
    end else if (rx_valid) begin
      gap_q <= '0;
    end else if (gap_q != GW'(GAP_CYCLES)) begin
      gap_q <= GW'(gap_q + 1'b1);
    end
  end
  // silence longer than 3.5 characters closes the frame
  assign frame_end = (gap_q == GW'(GAP_CYCLES - 1)) && !rx_valid
                     && (rx_cnt_q != '0) && (state_q == ST_IDLE);

  // byte collection, only while idle; the master must wait for our reply
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_cnt_q <= '0;
      rx_ovf_q <= 1'b0;
      crc_rx_q <= RTU_CRC_INIT;
    end else if (state_q == ST_CHECK) begin
      // cleared only after the check has read the count and the crc
      rx_cnt_q <= '0;
      rx_ovf_q <= 1'b0;
      crc_rx_q <= RTU_CRC_INIT;
    end else if (state_q == ST_IDLE && rx_valid) begin
      crc_rx_q <= rtu_crc_step(crc_rx_q, rx_data);
      if (rx_cnt_q == 4'(RTU_REQ_BYTES)) begin
        rx_ovf_q <= 1'b1; // too long for any supported request
      end else begin
        rx_cnt_q <= 4'(rx_cnt_q + 1'b1);
      end
    end
  end

  // request byte store, addressed by arrival index
  always_ff @(posedge clk) begin
    if (state_q == ST_IDLE && rx_valid && !frame_end
        && rx_cnt_q != 4'(RTU_REQ_BYTES)) begin
      rx_mem_q[rx_cnt_q[2:0]] <= rx_data;
    end
  end

  // frame handler sequence
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      bcast_q <= 1'b0;
      rep_err_q <= 1'b0;
      err_code_q <= '0;
      word_n_q <= '0;
      word_ix_q <= '0;
      tx_ix_q <= '0;
      crc_err <= 1'b0;
      frame_drop <= 1'b0;
    end else begin
      crc_err <= 1'b0;
      frame_drop <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // nothing is sent unless a frame arrives first
          if (frame_end) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          bcast_q <= (req_station == RTU_BCAST_ADDR);
          word_ix_q <= '0;
          tx_ix_q <= '0;
          rep_err_q <= 1'b0;
          if (crc_rx_q != RTU_CRC_RESIDUE) begin
            crc_err <= 1'b1;
            frame_drop <= 1'b1;
            state_q <= ST_IDLE;
          end else if (req_station != RTU_BCAST_ADDR
                       && (req_station != station_id
                           || station_id < RTU_MIN_STATION
                           || station_id > RTU_MAX_STATION)) begin
            frame_drop <= 1'b1;
            state_q <= ST_IDLE;
          end else if (rx_ovf_q || rx_cnt_q != 4'(RTU_REQ_BYTES)) begin
            // wrong length for a word request: malformed data
            rep_err_q <= 1'b1;
            err_code_q <= RTU_EC_DATA;
            state_q <= (req_station == RTU_BCAST_ADDR) ? ST_IDLE : ST_SEND;
          end else if (req_func == RTU_FN_READ) begin
            if (req_cnt == '0 || req_cnt > 16'(MAX_WORDS)) begin
              rep_err_q <= 1'b1;
              err_code_q <= RTU_EC_DATA;
              state_q <= (req_station == RTU_BCAST_ADDR) ? ST_IDLE
                                                         : ST_SEND;
            end else begin
              word_n_q <= req_cnt[3:0];
              state_q <= ST_ACCESS;
            end
          end else if (req_func == RTU_FN_WRITE) begin
            word_n_q <= 4'h1;
            state_q <= ST_ACCESS;
          end else begin
            // byte and bit operations fall here as unsupported
            rep_err_q <= 1'b1;
            err_code_q <= RTU_EC_FUNC;
            state_q <= (req_station == RTU_BCAST_ADDR) ? ST_IDLE : ST_SEND;
          end
        end
        ST_ACCESS: begin
          if (par_ack) begin
            if (par_fail) begin
              rep_err_q <= 1'b1;
              // a store without its own cause reports "cannot process"
              err_code_q <= (par_fail_code == '0) ? RTU_EC_BUSY
                                                  : par_fail_code;
              state_q <= bcast_q ? ST_IDLE : ST_SEND;
            end else if (word_ix_q == 4'(word_n_q - 1'b1)) begin
              state_q <= bcast_q ? ST_IDLE : ST_SEND;
            end else begin
              word_ix_q <= 4'(word_ix_q + 1'b1);
            end
          end
        end
        ST_SEND: begin
          // every own-address request with a good crc reaches here and gets its reply, if station_id is 1..247
          if (pushed) begin
            tx_ix_q <= IW'(tx_ix_q + 1'b1);
            if (tx_ix_q == IW'(rep_len - 1'b1)) begin
              state_q <= ST_CRC_LO;
            end
          end
        end
        ST_CRC_LO: begin
          if (pushed) begin
            state_q <= ST_CRC_HI;
          end
        end
        ST_CRC_HI: begin
          if (pushed) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // read words captured as they are acknowledged
  always_ff @(posedge clk) begin
    if (state_q == ST_ACCESS && par_ack && !par_fail && !par_we) begin
      words_q[word_ix_q] <= par_rdata;
    end
  end

  // parameter store request; held until acknowledged
  assign par_req = (state_q == ST_ACCESS);
  assign par_we = (req_func == RTU_FN_WRITE);
  // consecutive words follow the start address; wrap is the master's care
  assign par_addr = 16'(req_addr + {12'h000, word_ix_q});
  assign par_wdata = req_cnt;

  // reply byte selection by index
  always_comb begin
    logic [4:0] off;
    logic [15:0] w;
    off = 5'(tx_ix_q - 5'(RTU_RD_HDR_LEN));
    w = words_q[off[4:1]];
    rep_byte = 8'h00;
    rep_len = IW'(RTU_WR_ECHO_LEN);
    if (rep_err_q) begin
      rep_len = IW'(RTU_ERR_LEN);
      if (tx_ix_q == IW'(RTU_IX_ADDR)) begin
        rep_byte = req_station;
      end else if (tx_ix_q == IW'(RTU_IX_FUNC)) begin
        rep_byte = req_func | RTU_FN_ERR_FLAG;
      end else begin
        rep_byte = err_code_q;
      end
    end else if (req_func == RTU_FN_READ) begin
      rep_len = IW'(5'(RTU_RD_HDR_LEN) + {word_n_q, 1'b0});
      if (tx_ix_q == IW'(RTU_IX_ADDR)) begin
        rep_byte = req_station;
      end else if (tx_ix_q == IW'(RTU_IX_FUNC)) begin
        rep_byte = req_func;
      end else if (tx_ix_q == IW'(RTU_RD_HDR_LEN - 1)) begin
        rep_byte = {3'b000, word_n_q, 1'b0}; // byte count
      end else begin
        rep_byte = off[0] ? w[7:0] : w[15:8];
      end
    end else begin
      // write reply echoes the request without its crc
      rep_byte = rx_mem_q[tx_ix_q[2:0]];
    end
  end

  // bytes into the buffer, crc low byte first then high
  always_comb begin
    push_s.valid = (state_q == ST_SEND) || (state_q == ST_CRC_LO)
                   || (state_q == ST_CRC_HI);
    if (state_q == ST_CRC_LO) begin
      push_s.data = crc_tx_q[7:0];
    end else if (state_q == ST_CRC_HI) begin
      push_s.data = crc_tx_q[15:8];
    end else begin
      push_s.data = rep_byte;
    end
  end
  assign pushed = push_s.valid & push_s.ready;

  // reply crc, restarted per frame, fed with each body byte
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      crc_tx_q <= RTU_CRC_INIT;
    end else if (state_q == ST_CHECK) begin
      crc_tx_q <= RTU_CRC_INIT;
    end else if (state_q == ST_SEND && pushed) begin
      crc_tx_q <= rtu_crc_step(crc_tx_q, rep_byte);
    end
  end

  // buffer absorbs uart stalls so no reply byte is lost
  rtu_pipe2 #(.WIDTH(8), .DEPTH(2)) u_pipe (
    .clk(clk),
    .rst_b(rst_b),
    .in_s(push_s),
    .out_s(pop_s),
    .empty(buf_empty)
  );
  assign tx_data = pop_s.data;
  assign tx_valid = pop_s.valid;
  assign pop_s.ready = tx_ready;

  // driver enable: only while a reply is pending or still shifting out
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_en <= 1'b0;
    end else begin
      tx_en <= push_s.valid || !buf_empty || tx_busy;
    end
  end
endmodule : rtu_frame_handler

// [core/rtu_pipe2.sv]
// small fifo in the reply byte path, two entries by default
// assumes one clock; upstream and downstream use valid/ready
`timescale 1ns/10ps
module rtu_pipe2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  rtu_strm_if.snk in_s,
  rtu_strm_if.src out_s,
  output logic empty
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH]; // entry storage
  logic [AW-1:0] wr_q; // write index
  logic [AW-1:0] rd_q; // read index
  logic [CW-1:0] cnt_q; // entries held
  logic push; // word taken in
  logic pop; // word handed out

  // honest full and empty from the count
  assign in_s.ready = (cnt_q != CW'(DEPTH));
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data = mem_q[rd_q];
  assign empty = (cnt_q == '0);
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  // index wrap shared by both pointers
  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : nxt

  // storage writes
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_s.data;
    end
  end

  // pointers and count
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= nxt(wr_q);
      end
      if (pop) begin
        rd_q <= nxt(rd_q);
      end
      if (push && !pop) begin
        cnt_q <= CW'(cnt_q + 1'b1);
      end else if (pop && !push) begin
        cnt_q <= CW'(cnt_q - 1'b1);
      end
    end
  end
endmodule : rtu_pipe2

// [core/rtu_pkg.sv]
// constants, state codes and the crc step for the rtu slave frame handler
// assumes a 20 MHz system clock and a byte-wide uart on the same clock
package rtu_pkg;
  // station addressing
  localparam logic [7:0] RTU_BCAST_ADDR = 8'h00; // reaches every station
  localparam logic [7:0] RTU_MIN_STATION = 8'h01;
  localparam logic [7:0] RTU_MAX_STATION = 8'hF7;
  // operation codes
  localparam logic [7:0] RTU_FN_READ = 8'h03;
  localparam logic [7:0] RTU_FN_WRITE = 8'h06;
  localparam logic [7:0] RTU_FN_ERR_FLAG = 8'h80; // or-ed into error replies
  // error cause codes
  localparam logic [7:0] RTU_EC_FUNC = 8'h01;
  localparam logic [7:0] RTU_EC_ADDR = 8'h02;
  localparam logic [7:0] RTU_EC_DATA = 8'h03;
  localparam logic [7:0] RTU_EC_BUSY = 8'h04;
  // crc
  localparam logic [15:0] RTU_CRC_INIT = 16'hFFFF;
  localparam logic [15:0] RTU_CRC_POLY = 16'hA001;
  localparam logic [15:0] RTU_CRC_RESIDUE = 16'h0000; // crc over frame+crc
  // request layout, byte index within the frame
  localparam int RTU_REQ_BYTES = 8;
  localparam int RTU_IX_ADDR = 0;
  localparam int RTU_IX_FUNC = 1;
  localparam int RTU_IX_RA_HI = 2;
  localparam int RTU_IX_RA_LO = 3;
  localparam int RTU_IX_CN_HI = 4; // word count, or data on a write
  localparam int RTU_IX_CN_LO = 5;
  localparam int RTU_MAX_WORDS = 12;
  localparam int RTU_ERR_LEN = 3; // addr, flagged func, cause
  localparam int RTU_RD_HDR_LEN = 3; // addr, func, byte count
  localparam int RTU_WR_ECHO_LEN = 6; // addr, func, address, data
  // timing: idle gap is 3.5 characters, kept here as 7 half characters
  localparam longint RTU_CLK_HZ = 20_000_000;
  localparam longint RTU_BAUD_DEF = 9600;
  localparam longint RTU_CHAR_BITS = 11;
  localparam longint RTU_GAP_HALF_CHARS = 7;
  // least time, so rounded up to whole cycles
  localparam longint RTU_GAP_CYCLES_DEF =
    (RTU_CLK_HZ * RTU_CHAR_BITS * RTU_GAP_HALF_CHARS + 2 * RTU_BAUD_DEF - 1)
    / (2 * RTU_BAUD_DEF);

  // one-hot frame handler states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_CHECK = 6'b000010,
    ST_ACCESS = 6'b000100,
    ST_SEND = 6'b001000,
    ST_CRC_LO = 6'b010000,
    ST_CRC_HI = 6'b100000
  } rtu_state_type;

  // one byte folded into the crc, eight lsb-first shifts
  function automatic logic [15:0] rtu_crc_step(input logic [15:0] crc,
                                               input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      if (c[0]) begin
        c = (c >> 1) ^ RTU_CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction : rtu_crc_step
endpackage : rtu_pkg

// [core/rtu_strm_if.sv]
// byte stream carrier between the frame handler and its output buffer
// assumes both ends share one clock
`timescale 1ns/10ps
interface rtu_strm_if #(parameter int WIDTH = 8);
  logic valid; // source offers data
  logic ready; // sink takes it this cycle
  logic [WIDTH-1:0] data; // payload
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : rtu_strm_if

// [sim/rtu_fh_props.sv]
// port assertions for the rtu slave frame handler
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module rtu_fh_props #(
  parameter longint GAP_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_en,
  input wire logic par_req,
  input wire logic par_we,
  input wire logic [15:0] par_addr,
  input wire logic [15:0] par_wdata,
  input wire logic par_ack,
  input wire logic crc_err,
  input wire logic frame_drop
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic [19:0] quiet_q; // cycles since the last received byte
  logic heard_q; // a byte arrived since reset
  // quiet time, saturating so a long idle never wraps back to zero
  always_ff @(posedge clk) begin
    if (!rst_b || rx_valid) begin
      quiet_q <= 20'h00000;
    end else if (quiet_q != 20'hFFFFF) begin
      quiet_q <= quiet_q + 20'h00001;
    end
  end
  // remembers that the master has spoken
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      heard_q <= 1'b0;
    end else if (rx_valid) begin
      heard_q <= 1'b1;
    end
  end
  property p_answer_only;
    $rose(tx_en) |-> heard_q && quiet_q >= GAP_CYCLES - 1;
  endproperty
  a_answer_only: assert property (p_answer_only)
    else $error("reply began before a request ended");
  property p_drop_cause;
    crc_err |-> frame_drop;
  endproperty
  a_drop_cause: assert property (p_drop_cause)
    else $error("crc error without a drop");
  property p_drop_pulse;
    frame_drop |=> !frame_drop;
  endproperty
  a_drop_pulse: assert property (p_drop_pulse)
    else $error("drop pulse too long");
  property p_drop_silent;
    frame_drop |-> (!tx_valid && !tx_en) [*8];
  endproperty
  a_drop_silent: assert property (p_drop_silent)
    else $error("dropped frame was answered");
  property p_tx_gated;
    tx_valid |-> tx_en;
  endproperty
  a_tx_gated: assert property (p_tx_gated)
    else $error("byte offered with line driver off");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("stalled reply byte changed");
  property p_par_hold;
    par_req && !par_ack |=> par_req && $stable({par_addr, par_we, par_wdata});
  endproperty
  a_par_hold: assert property (p_par_hold)
    else $error("store request changed before ack");
  property p_par_next;
    par_req && par_ack && !par_we |=>
      !par_req || par_addr == $past(par_addr) + 16'h0001;
  endproperty
  a_par_next: assert property (p_par_next)
    else $error("next read word not at address plus one");
  c_reply: cover property (tx_valid && tx_ready);
  c_crc: cover property (crc_err);
  c_write: cover property (par_ack && par_we);
endmodule : rtu_fh_props

bind rtu_frame_handler rtu_fh_props #(.GAP_CYCLES(GAP_CYCLES)) props_u (
  .clk(clk), .rst_b(rst_b), .rx_valid(rx_valid), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_en(tx_en),
  .par_req(par_req), .par_we(par_we), .par_addr(par_addr),
  .par_wdata(par_wdata), .par_ack(par_ack), .crc_err(crc_err),
  .frame_drop(frame_drop)
);

// [sim/rtu_store_model.sv]
// parameter store stand-in: word data, fails on addresses 0xEExx
// assumes one clock; lag sets extra wait cycles before each ack
`timescale 1ns/10ps
module rtu_store_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] lag,
  input wire logic par_req,
  input wire logic par_we,
  input wire logic [15:0] par_addr,
  input wire logic [15:0] par_wdata,
  output logic par_ack,
  output logic [15:0] par_rdata,
  output logic par_fail,
  output logic [7:0] par_fail_code,
  output logic [15:0] wr_addr,
  output logic [15:0] wr_data
);
  logic [1:0] wait_q; // cycles waited on the current request
  // read data toggles when idle so a stale word never looks valid
  always_ff @(posedge clk) begin
    par_ack <= 1'b0;
    par_fail <= 1'b0;
    par_rdata <= ~par_rdata;
    if (!rst_b) begin
      par_rdata <= 16'h0000;
      par_fail_code <= 8'h00;
      wait_q <= 2'h0;
      wr_addr <= 16'h0000;
      wr_data <= 16'h0000;
    end else if (par_req && !par_ack) begin
      if (wait_q == lag) begin
        wait_q <= 2'h0;
        par_ack <= 1'b1;
        par_rdata <= par_addr ^ 16'h5A5A;
        par_fail <= par_addr[15:8] == 8'hEE;
        par_fail_code <= par_addr[7:0];
        if (par_we) begin
          wr_addr <= par_addr;
          wr_data <= par_wdata;
        end
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule : rtu_store_model

// [sim/test_rtu_frame_handler.sv]
// self-checking bench for the rtu slave frame handler
// assumes the store model and the checker are compiled beforehand
`timescale 1ns/10ps
module test_rtu_frame_handler import rtu_pkg::*;;
  typedef logic [7:0] rtu_bq_type[$];
  localparam longint GAP = 20; // short idle gap keeps the run brief
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] station_id = 8'h11; // own station
  logic [7:0] rx_data = 8'h00;
  logic rx_valid = 1'b0;
  logic tx_ready = 1'b0;
  logic tx_busy = 1'b0;
  logic [1:0] lag = 2'h0; // store answer delay
  logic [7:0] tx_data, par_fail_code;
  logic tx_valid, tx_en, par_req, par_we, par_ack, par_fail;
  logic crc_err, frame_drop;
  logic [15:0] par_addr, par_wdata, par_rdata, wr_addr, wr_data;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int busy_len = 0; // uart shift time per byte
  int busy_n = 0;
  int crc_errs = 0;
  int drops = 0;
  rtu_bq_type got; // reply bytes taken from the design
  always #25 clk = ~clk;
  rtu_frame_handler #(.GAP_CYCLES(GAP), .MAX_WORDS(RTU_MAX_WORDS)) dut_u (
    .clk(clk), .rst_b(rst_b), .station_id(station_id), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_busy(tx_busy), .tx_en(tx_en), .par_req(par_req),
    .par_we(par_we), .par_addr(par_addr), .par_wdata(par_wdata),
    .par_ack(par_ack), .par_rdata(par_rdata), .par_fail(par_fail),
    .par_fail_code(par_fail_code), .crc_err(crc_err), .frame_drop(frame_drop)
  );
  rtu_store_model mdl_u (
    .clk(clk), .rst_b(rst_b), .lag(lag), .par_req(par_req), .par_we(par_we),
    .par_addr(par_addr), .par_wdata(par_wdata), .par_ack(par_ack),
    .par_rdata(par_rdata), .par_fail(par_fail),
    .par_fail_code(par_fail_code), .wr_addr(wr_addr), .wr_data(wr_data)
  );
  // uart stand-in, drop counters and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tx_valid === 1'b1 && tx_ready) begin
      got.push_back(tx_data);
      busy_n <= busy_len;
    end else if (busy_n > 0) begin
      busy_n <= busy_n - 1;
    end
    if (crc_err === 1'b1) crc_errs++;
    if (frame_drop === 1'b1) drops++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // a long shift time holds ready low and fills the reply buffer
  always @(negedge clk) begin
    tx_ready <= rst_b && busy_n == 0;
    tx_busy <= busy_n != 0;
  end
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  // reflected crc, all ones start, low byte appended first
  function automatic rtu_bq_type add_crc(input rtu_bq_type b);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    return b;
  endfunction : add_crc
  // mode 0 sends a good frame, 1 spoils the crc, 2 sends bytes bare
  task automatic xfer(input rtu_bq_type rq, input rtu_bq_type e,
                      input int mode);
    int n;
    got.delete();
    if (mode != 2) rq = add_crc(rq);
    if (mode == 1) rq[7] = ~rq[7];
    foreach (rq[i]) begin
      @(negedge clk);
      rx_data = rq[i];
      rx_valid = 1'b1;
      @(negedge clk);
      rx_valid = 1'b0;
    end
    n = 0;
    while (n < 600 && !(got.size() > 0 && tx_en === 1'b0 && !tx_busy)) begin
      @(negedge clk);
      n++;
    end
    if (e.size() > 0) e = add_crc(e);
    check("reply length", got.size(), e.size());
    foreach (e[i]) check("reply byte", got[i], e[i]);
  endtask : xfer
  task automatic t_read(input logic [15:0] cnt, input logic [1:0] l,
                        input int bl);
    rtu_bq_type e;
    logic [15:0] d;
    lag = l;
    busy_len = bl;
    e = '{8'h11, RTU_FN_READ, {cnt[6:0], 1'b0}};
    for (int w = 0; w < cnt; w++) begin
      d = (16'h1000 + w[15:0]) ^ 16'h5A5A;
      e.push_back(d[15:8]);
      e.push_back(d[7:0]);
    end
    xfer('{8'h11, RTU_FN_READ, 8'h10, 8'h00, cnt[15:8], cnt[7:0]}, e, 0);
  endtask : t_read
  task automatic t_write();
    lag = 2'h1;
    busy_len = 0;
    xfer('{8'h11, RTU_FN_WRITE, 8'h20, 8'h00, 8'h00, 8'h05},
         '{8'h11, RTU_FN_WRITE, 8'h20, 8'h00, 8'h00, 8'h05}, 0);
    check("write address", wr_addr, 16'h2000);
    check("write data", wr_data, 16'h0005);
  endtask : t_write
  task automatic t_errors();
    logic [7:0] op[6] = '{8'h04, 8'h03, 8'h03, 8'h03, 8'h03, 8'h06};
    logic [15:0] ad[6] = '{16'h1000, 16'h1000, 16'h1000, 16'hEE02,
                           16'hEE00, 16'hEE03};
    logic [15:0] cn[6] = '{16'h0001, 16'h0000, 16'h000D, 16'h0001,
                           16'h0001, 16'h0000};
    logic [7:0] cs[6] = '{RTU_EC_FUNC, RTU_EC_DATA, RTU_EC_DATA,
                          RTU_EC_ADDR, RTU_EC_BUSY, RTU_EC_DATA};
    foreach (op[i]) begin
      xfer('{8'h11, op[i], ad[i][15:8], ad[i][7:0], cn[i][15:8], cn[i][7:0]},
           '{8'h11, op[i] | RTU_FN_ERR_FLAG, cs[i]}, 0);
    end
  endtask : t_errors
  task automatic t_silent();
    int d0;
    int c0;
    d0 = drops;
    c0 = crc_errs;
    xfer('{8'h00, RTU_FN_WRITE, 8'h20, 8'h01, 8'h12, 8'h34}, '{}, 0);
    check("broadcast address", wr_addr, 16'h2001);
    check("broadcast data", wr_data, 16'h1234);
    xfer('{8'h12, RTU_FN_READ, 8'h10, 8'h00, 8'h00, 8'h01}, '{}, 0);
    xfer('{8'h11, RTU_FN_READ, 8'h10, 8'h00, 8'h00, 8'h01}, '{}, 1);
    xfer('{8'h11, RTU_FN_READ, 8'h10}, '{}, 2);
    check("crc drops", crc_errs - c0, 16'h0002);
    check("all drops", drops - d0, 16'h0003);
  endtask : t_silent
  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    check("idle line enable", tx_en, 16'h0000);
    t_read(16'h000C, 2'h2, 8);
    t_read(16'h0001, 2'h0, 0);
    t_write();
    t_errors();
    t_silent();
    give_verdict();
  end
endmodule : test_rtu_frame_handler
